// *** hw/rx_filter_pkg.sv ***
// package: constants, register map and carrier types of the receive address filter
package rx_filter_pkg;

  // destination address geometry
  localparam int unsigned DA_BITS = 48;
  localparam int unsigned DA_BYTES = 6;
  localparam int unsigned HASH_REGS = 8;
  localparam int unsigned HASH_BITS = 6;
  localparam logic [5:0] DA_LAST_BIT = 6'h2f;

  // crc generator
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;

  // register byte addresses on the apb bus, one aligned word each
  localparam logic [7:0] ADDR_STATION0 = 8'h00; // station bytes 0..5 at 00..14
  localparam logic [7:0] ADDR_HASH0 = 8'h18; // hash filter bytes 0..7 at 18..34
  localparam logic [7:0] ADDR_RX_CFG = 8'h38;
  localparam logic [7:0] ADDR_STATUS = 8'h3c;
  localparam logic [3:0] IDX_STATION0 = 4'h0;
  localparam logic [3:0] IDX_HASH0 = 4'h6;
  localparam logic [3:0] IDX_RX_CFG = 4'he;
  localparam logic [3:0] IDX_STATUS = 4'hf;

  // rx configuration field positions
  localparam int unsigned CFG_AB_POS = 0;
  localparam int unsigned CFG_AM_POS = 1;
  localparam int unsigned CFG_PRO_POS = 2;

  // reset values
  localparam logic [7:0] STATION_RESET = 8'h00;
  localparam logic [7:0] HASH_RESET = 8'h00;
  localparam logic [2:0] RX_CFG_RESET = 3'h0;

  typedef struct packed {
    logic promiscuous_cfg;
    logic accept_multicast_cfg;
    logic accept_broadcast_cfg;
  } rx_cfg_s;

  typedef struct packed {
    logic [5:0] hash_index;
    logic is_multicast;
    logic accept;
    logic broadcast;
    logic multicast;
    logic unicast;
  } filt_result_s;

  localparam filt_result_s RESULT_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_REST = 3'b100
  } rx_state_e;

endpackage : rx_filter_pkg

// *** hw/crc32_bit_step.sv ***
// one serial step of the 32-bit frame check crc
`timescale 1ns/1ps
`default_nettype none
module crc32_bit_step
(
  input wire logic [31:0] crc_in,
  input wire logic data_bit,
  output logic [31:0] crc_out
);

  logic feedback;

  // shift left, fold the polynomial in when top bit and data differ
  always_comb
  begin
    feedback = crc_in[31] ^ data_bit;
    crc_out = {crc_in[30:0], 1'b0} ^ (feedback ? rx_filter_pkg::CRC_POLY : 32'h00000000);
  end

endmodule : crc32_bit_step
`default_nettype wire

// *** hw/addr_byte_match.sv ***
// equality compare of one received address byte with one station byte
`timescale 1ns/1ps
`default_nettype none
module addr_byte_match
(
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] station_byte,
  output logic equal
);

  // byte wide compare
  assign equal = (rx_byte == station_byte);

endmodule : addr_byte_match
`default_nettype wire

// *** hw/rx_destination_address_filter.sv ***
// receive destination address filter: unicast, hash multicast, broadcast, apb registers
`timescale 1ns/1ps
`default_nettype none
module rx_destination_address_filter
(
  input wire logic CLOCK,
  input wire logic SRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // receive bit stream
  input wire logic RX_FRAME_START,
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  // filter results
  output logic RESULT_VALID,
  output logic UNICAST_MATCH,
  output logic MULTICAST_MATCH,
  output logic BROADCAST_MATCH,
  output logic IS_MULTICAST,
  output logic ACCEPT,
  output logic [5:0] HASH_INDEX
);

  // register storage
  logic [7:0] station_q [rx_filter_pkg::DA_BYTES];
  logic [7:0] station_d [rx_filter_pkg::DA_BYTES];
  logic [7:0] hash_q [rx_filter_pkg::HASH_REGS];
  logic [7:0] hash_d [rx_filter_pkg::HASH_REGS];
  rx_filter_pkg::rx_cfg_s cfg_q;
  rx_filter_pkg::rx_cfg_s cfg_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic slverr_q;
  logic slverr_d;

  // receive side state
  rx_filter_pkg::rx_state_e state_q;
  rx_filter_pkg::rx_state_e state_d;
  logic [5:0] bit_cnt_q;
  logic [5:0] bit_cnt_d;
  logic [47:0] da_q;
  logic [47:0] da_d;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [31:0] crc_cur;
  logic [31:0] crc_next;
  rx_filter_pkg::filt_result_s result_q;
  rx_filter_pkg::filt_result_s result_d;
  logic valid_q;
  logic valid_d;

  // decode helpers
  logic [3:0] reg_idx;
  logic addr_ok;
  logic wr_en;
  logic setup;
  logic take_bit;
  logic last_bit;
  logic [5:0] byte_eq;
  logic [63:0] hash_bits;
  logic [5:0] hash_idx;
  logic uni;
  logic mul;
  logic bro;
  logic is_mc;
  logic [31:0] status_word;

  // apb decode: word index from the byte address, top bits must be clear
  assign reg_idx = PADDR[5:2];
  assign addr_ok = (PADDR[7:6] == 2'b00) && (PADDR[1:0] == 2'b00);
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && !slverr_q;

  // no wait states: read data and error are latched in the setup cycle
  assign PREADY = PSEL && PENABLE;
  assign PRDATA = prdata_q;
  assign PSLVERR = slverr_q && PSEL && PENABLE;

  // status word: valid flag in bit 0, result fields in bits 11..1, upper bits zero
  assign status_word = {20'h00000, result_q, valid_q};

  // flatten the hash bytes into filter bits 0..63
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      hash_bits[n*8 +: 8] = hash_q[n];
    end
  end

  // register write and read-data next values
  always_comb
  begin
    station_d = station_q;
    hash_d = hash_q;
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    // read word and error are latched in the setup cycle and stand through the access
    if (setup)
    begin
      prdata_d = 32'h00000000;
      slverr_d = !addr_ok;
      if (addr_ok)
      begin
        if (reg_idx < rx_filter_pkg::IDX_HASH0)
        begin
          prdata_d[7:0] = station_q[3'(reg_idx)];
        end
        else if (reg_idx < rx_filter_pkg::IDX_RX_CFG)
        begin
          prdata_d[7:0] = hash_q[3'(reg_idx - rx_filter_pkg::IDX_HASH0)];
        end
        else if (reg_idx == rx_filter_pkg::IDX_RX_CFG)
        begin
          prdata_d[2:0] = cfg_q;
        end
        else
        begin
          prdata_d = status_word;
        end
      end
    end
    // a write lands at the access edge; status and flagged addresses are left alone
    if (wr_en)
    begin
      if (reg_idx < rx_filter_pkg::IDX_HASH0)
      begin
        station_d[3'(reg_idx)] = PWDATA[7:0];
      end
      else if (reg_idx < rx_filter_pkg::IDX_RX_CFG)
      begin
        hash_d[3'(reg_idx - rx_filter_pkg::IDX_HASH0)] = PWDATA[7:0];
      end
      else if (reg_idx == rx_filter_pkg::IDX_RX_CFG)
      begin
        cfg_d = rx_filter_pkg::rx_cfg_s'(PWDATA[2:0]);
      end
    end
  end

  // register file flops
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      for (int n = 0; n < 6; n++)
      begin
        station_q[n] <= rx_filter_pkg::STATION_RESET;
      end
      for (int n = 0; n < 8; n++)
      begin
        hash_q[n] <= rx_filter_pkg::HASH_RESET;
      end
      cfg_q <= rx_filter_pkg::RX_CFG_RESET;
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end
    else
    begin
      station_q <= station_d;
      hash_q <= hash_d;
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // crc runs from the preset on the first address bit
  assign crc_cur = (bit_cnt_q == 6'h00) ? rx_filter_pkg::CRC_PRESET : crc_q;

  // one crc step per cycle, fed with the bit on offer
  crc32_bit_step u_crc
  (
    .crc_in(crc_cur),
    .data_bit(RX_BIT),
    .crc_out(crc_next)
  );

  // a bit is taken only while the address is collected, never in a start cycle
  assign take_bit = RX_BIT_VALID && (state_q == rx_filter_pkg::ST_ADDR) && !RX_FRAME_START;
  assign last_bit = take_bit && (bit_cnt_q == rx_filter_pkg::DA_LAST_BIT);

  // byte compares against the station address
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_byte
      addr_byte_match u_match
      (
        .rx_byte(da_d[g*8 +: 8]),
        .station_byte(station_q[g]),
        .equal(byte_eq[g])
      );
    end
  endgenerate

  // match results from the completed address
  always_comb
  begin
    uni = &byte_eq;
    hash_idx = crc_next[31:26];
    mul = hash_bits[hash_idx];
    bro = &da_d;
    is_mc = da_d[0];
  end

  // address capture state machine
  always_comb
  begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    da_d = da_q;
    crc_d = crc_q;
    result_d = result_q;
    valid_d = 1'b0;
    // a start pulse wins over a bit offered in the same cycle
    if (RX_FRAME_START)
    begin
      state_d = rx_filter_pkg::ST_ADDR;
      bit_cnt_d = 6'h00;
      da_d = 48'h000000000000;
    end
    else if (take_bit)
    begin
      da_d[bit_cnt_q] = RX_BIT;
      crc_d = crc_next;
      bit_cnt_d = bit_cnt_q + 6'h01;
      if (last_bit)
      begin
        state_d = rx_filter_pkg::ST_REST;
      end
    end
    if (last_bit)
    begin
      // decision latched beside the fields so both describe the same frame
      valid_d = 1'b1;
      result_d.unicast = uni;
      result_d.multicast = mul;
      result_d.broadcast = bro;
      result_d.is_multicast = is_mc;
      result_d.hash_index = hash_idx;
      result_d.accept = cfg_q.promiscuous_cfg
                        || (bro && cfg_q.accept_broadcast_cfg)
                        || (is_mc && !bro && mul && cfg_q.accept_multicast_cfg)
                        || (!is_mc && uni);
    end
  end

  // receive side flops
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state_q <= rx_filter_pkg::ST_IDLE;
      bit_cnt_q <= 6'h00;
      da_q <= 48'h000000000000;
      crc_q <= rx_filter_pkg::CRC_PRESET;
      result_q <= rx_filter_pkg::RESULT_RESET;
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      da_q <= da_d;
      crc_q <= crc_d;
      result_q <= result_d;
      valid_q <= valid_d;
    end
  end

  // result outputs straight from flops
  assign RESULT_VALID = valid_q;
  assign UNICAST_MATCH = result_q.unicast;
  assign MULTICAST_MATCH = result_q.multicast;
  assign BROADCAST_MATCH = result_q.broadcast;
  assign IS_MULTICAST = result_q.is_multicast;
  assign ACCEPT = result_q.accept;
  assign HASH_INDEX = result_q.hash_index;

endmodule : rx_destination_address_filter
`default_nettype wire

// *** bench/rx_filter_sva.sv ***
// checker: port assertions of the receive address filter
`timescale 1ns/1ps
`default_nettype none
module rx_filter_sva
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RX_FRAME_START,
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  input wire logic RESULT_VALID,
  input wire logic UNICAST_MATCH,
  input wire logic BROADCAST_MATCH,
  input wire logic IS_MULTICAST,
  input wire logic ACCEPT,
  input wire logic [5:0] HASH_INDEX
);
  logic [5:0] cnt_q;
  logic [47:0] da_q;
  wire logic take = RX_BIT_VALID && !RX_FRAME_START && cnt_q < 6'h30;
  wire logic last = take && cnt_q == 6'h2f;
  wire logic bad = PADDR[7:6] != 2'h0 || PADDR[1:0] != 2'h0;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // collects address bits in arrival order
  always_ff @(posedge CLOCK)
  begin
    if (SRST || RX_FRAME_START)
      cnt_q <= SRST ? 6'h30 : 6'h0;
    else if (take)
    begin
      da_q[cnt_q] <= RX_BIT;
      cnt_q <= cnt_q + 6'h1;
    end
  end
  a_ready_access: assert property (PREADY == (PSEL && PENABLE)) else $error("pready");
  a_err_unmapped: assert property (PSEL && PENABLE |-> PSLVERR == bad) else $error("pslverr");
  a_last_bit: assert property (last |=> RESULT_VALID) else $error("no result");
  a_result_cause: assert property (RESULT_VALID |-> $past(last)) else $error("early result");
  a_fields_hold: assert property (!RESULT_VALID && !$past(SRST) |->
    $stable(HASH_INDEX) && $stable(ACCEPT)) else $error("fields moved");
  a_bcast_ones: assert property (RESULT_VALID |-> BROADCAST_MATCH == &da_q) else $error("bcast");
  a_mc_first: assert property (RESULT_VALID |-> IS_MULTICAST == da_q[0]) else $error("mcast");
  a_accept_uni: assert property (RESULT_VALID && !IS_MULTICAST && UNICAST_MATCH |-> ACCEPT)
    else $error("accept");
endmodule : rx_filter_sva
bind rx_destination_address_filter rx_filter_sva u_sva (.CLOCK, .SRST, .PSEL, .PENABLE, .PADDR, .PREADY,
  .PSLVERR, .RX_FRAME_START, .RX_BIT_VALID, .RX_BIT, .RESULT_VALID, .UNICAST_MATCH, .BROADCAST_MATCH,
  .IS_MULTICAST, .ACCEPT, .HASH_INDEX);
`default_nettype wire

// *** bench/rx_bit_source.sv ***
// receive path model: start pulse then address bits
`timescale 1ns/1ps
`default_nettype none
module rx_bit_source
(
  input wire logic clk,
  input wire logic go,
  input wire logic [47:0] addr,
  input wire logic [5:0] len,
  input wire logic slow,
  output logic start,
  output logic valid,
  output logic bit_o,
  output logic busy
);
  logic [5:0] n = 6'h0;
  logic gap = 1'b0;
  initial {start, valid, bit_o, busy} = 4'h0;
  // idle line toggles so a stale bit never looks valid
  always @(posedge clk)
  begin
    start <= 1'b0;
    valid <= 1'b0;
    bit_o <= !bit_o;
    if (go && !busy)
      {start, busy, n} <= {2'b11, 6'h0};
    else if (busy && n == len)
      busy <= 1'b0;
    else if (busy && gap)
      gap <= 1'b0;
    else if (busy)
    begin
      {valid, bit_o, gap} <= {1'b1, addr[n], slow};
      n <= n + 6'h1;
    end
  end
endmodule : rx_bit_source
`default_nettype wire

// *** bench/rx_destination_address_filter_tb_top.sv ***
// testbench: register access and frame filtering
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module rx_destination_address_filter_tb_top;
  logic CLOCK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, RX_FRAME_START, RX_BIT_VALID, RX_BIT, RESULT_VALID, e, busy;
  logic UNICAST_MATCH, MULTICAST_MATCH, BROADCAST_MATCH, IS_MULTICAST, ACCEPT;
  logic [5:0] HASH_INDEX, len = 6'h30;
  logic [47:0] st, a = 48'h0;
  logic [63:0] hf;
  logic [2:0] cf;
  int seed = 47176, n_mismatch = 0, num_checks = 0;
  rx_filter_pkg::filt_result_s q[$], x;
  wire rx_filter_pkg::filt_result_s got = {HASH_INDEX, IS_MULTICAST, ACCEPT, BROADCAST_MATCH,
    MULTICAST_MATCH, UNICAST_MATCH};
  always #2.5 CLOCK = !CLOCK;
  rx_destination_address_filter DUT (.CLOCK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .RX_FRAME_START, .RX_BIT_VALID, .RX_BIT, .RESULT_VALID, .UNICAST_MATCH, .MULTICAST_MATCH,
    .BROADCAST_MATCH, .IS_MULTICAST, .ACCEPT, .HASH_INDEX);
  rx_bit_source src (.clk(CLOCK), .go, .addr(a), .len, .slow, .start(RX_FRAME_START), .valid(RX_BIT_VALID),
    .bit_o(RX_BIT), .busy);
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // a wait that ran out ends the run
  task lim(input int k, input int m);
    if (k >= m)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : lim
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge CLOCK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, ad, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge CLOCK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 20);
    {r, e} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
    lim(k, 20);
  endtask : apb
  task rd(input logic [7:0] ad, input logic [31:0] ex, input logic er);
    apb(1'b0, ad, 32'h0);
    `CHK("prdata", ex, r)
    `CHK("pslverr", er, e)
  endtask : rd
  task prog;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 6) apb(1'b1, 8'(4 * i), {24'hffffff, st[8 * i +: 8]});
      apb(1'b1, rx_filter_pkg::ADDR_HASH0 + 8'(4 * i), {24'hffffff, hf[8 * i +: 8]});
    end
  endtask : prog
  // expected result worked out from the programmed registers
  function automatic rx_filter_pkg::filt_result_s exp_of(input logic [47:0] d);
    rx_filter_pkg::filt_result_s t;
    logic [31:0] c;
    c = rx_filter_pkg::CRC_PRESET;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? rx_filter_pkg::CRC_POLY : 32'h0);
    t.hash_index = c[31:26];
    t.is_multicast = d[0];
    t.broadcast = &d;
    t.multicast = hf[c[31:26]];
    t.unicast = d == st;
    t.accept = cf[2] | (t.broadcast & cf[0]) | (d[0] & !t.broadcast & t.multicast & cf[1]) | (!d[0] & t.unicast);
    return t;
  endfunction : exp_of
  task frame(input logic [47:0] d, input logic [5:0] ln);
    int k;
    if (ln == 6'h30) q.push_back(exp_of(d));
    @(posedge CLOCK);
    {a, len, go} <= {d, ln, 1'b1};
    @(posedge CLOCK);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge CLOCK);
      k++;
    end
    while ((busy === 1'b1 || k < 2) && k < 200);
    lim(k, 200);
    repeat (2) @(posedge CLOCK);
  endtask : frame
  // compares each result pulse with the oldest expectation
  always @(posedge CLOCK)
  begin
    if (RESULT_VALID === 1'b1)
    begin
      x = (q.size() > 0) ? q.pop_front() : 'x;
      `CHK("result", x, got)
    end
  end
  initial
  begin
    repeat (10) @(posedge CLOCK);
    SRST <= 1'b0;
    for (int i = 0; i < 16; i++) rd(8'(4 * i), 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    rd(8'h05, 32'h0, 1'b1);
    st = 48'({$random(seed), $random(seed)}) & 48'hfffffffffffe;
    hf = {$random(seed), $random(seed)};
    prog();
    rd(8'h14, {24'h0, st[47:40]}, 1'b0);
    rd(8'h34, {24'h0, hf[63:56]}, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      cf = 3'(c);
      slow <= cf[0];
      apb(1'b1, rx_filter_pkg::ADDR_RX_CFG, {29'h0, cf});
      frame(st, 6'h30);
      frame(st ^ (48'h1 << (40 + c)), 6'h30);
      frame('1, 6'h30);
      frame(48'({$random(seed), $random(seed)}) | 48'h1, 6'h30);
    end
    rd(rx_filter_pkg::ADDR_STATUS, {20'h0, x, 1'b0}, 1'b0);
    frame(st, 6'h14);
    frame(st, 6'h30);
    hf = '1;
    prog();
    cf = 3'h2;
    apb(1'b1, rx_filter_pkg::ADDR_RX_CFG, 32'h2);
    repeat (3) frame(48'({$random(seed), $random(seed)}) | 48'h1, 6'h30);
    SRST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    SRST <= 1'b0;
    rd(8'h14, 32'h0, 1'b0);
    `CHK("pending", 0, q.size())
    stop_test();
  end
endmodule : rx_destination_address_filter_tb_top
`default_nettype wire
